/* rtl/fdd_top.sv */
// Fault diagnostics, trouble-code manager and DM1 reaction table
//
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
module fdd_top #(
	parameter int TICK_CYCLES = fdd_pkg::MS_CYCLES
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic [15:0] supply_mv_i,
	input wire logic [15:0] temperature_i,
	input wire logic can_rx_timeout_i,
	input wire logic can_rx_msg_i,
	input wire logic [3:0] input_on_i,
	input wire logic dm11_i,
	input wire logic dm3_i,
	input wire logic dm1_valid_i,
	input wire logic [18:0] dm1_spn_i,
	input wire logic [4:0] dm1_fmi_i,
	input wire logic [7:0] dm1_sa_i,
	output wire logic [7:0] dtc_active_o,
	output logic outputs_disable_o,
	output wire logic [29:0] react_state_o
);

	logic [3:0] ctrl_r;
	logic [15:0] uv_thr_r;
	logic [15:0] ov_thr_r;
	logic [15:0] v_hyst_r;
	logic [15:0] t_thr_r;
	logic [15:0] t_hyst_r;
	logic [15:0] send_dly_r;
	logic [15:0] clr_dly_r;
	logic [7:0] sa_r;
	logic sa_en_r;
	logic uv_r;
	logic ov_r;
	logic ot_r;
	logic can_r;
	logic [fdd_pkg::TICK_W-1:0] tick_cnt_r;
	logic tick_r;
	logic [8:0] dtc_cfg_r [fdd_pkg::N_DTC];
	logic [7:0] occ_r [fdd_pkg::N_DTC];
	logic act_r [fdd_pkg::N_DTC];
	logic inp_q_r [fdd_pkg::N_INP];
	logic [15:0] inp_cnt_r [fdd_pkg::N_INP];
	logic [31:0] react_cfg_r [fdd_pkg::N_REACT];
	logic [11:0] react_tmr_r [fdd_pkg::N_REACT];
	logic react_st_r [fdd_pkg::N_REACT];
	logic [fdd_pkg::N_REACT-1:0] match_w;
	logic [fdd_pkg::N_DTC-1:0] fault_w;
	logic [31:0] rd_val;
	logic [31:0] wdata;
	logic wr_en;
	logic sa_ok;
	logic in_dtc;
	logic in_occ;
	logic in_react;

	// Threshold inside the supply range
	function automatic logic volt_ok(input logic [15:0] v);
		return (v >= fdd_pkg::VOLT_MIN_MV) && (v <= fdd_pkg::VOLT_MAX_MV);
	endfunction

	// Failure mode code that may be configured
	function automatic logic fmi_ok(input logic [4:0] f);
		return (f <= fdd_pkg::FMI_LAST_RANGE) || (f == fdd_pkg::FMI_COND_EXISTS);
	endfunction

	// Byte-lane merge of a write into the current register value
	function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++)
		begin
			if (be[b])
				res[8*b +: 8] = new_v[8*b +: 8];
		end
		return res;
	endfunction

	// Address window decode
	assign in_dtc = avs_address_i[7:5] == fdd_pkg::REG_DTC_BASE[7:5];
	assign in_occ = avs_address_i[7:5] == fdd_pkg::REG_OCC_BASE[7:5];
	assign in_react = avs_address_i[7] && (avs_address_i[6:2] < 5'(fdd_pkg::N_REACT));
	assign wr_en = avs_write_i && !avs_waitrequest_o;
	assign wdata = be_merge(rd_val, avs_writedata_i, avs_byteenable_i);

	// Wait one cycle, then answer for one cycle
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
			avs_waitrequest_o <= 1'b1;
		else if (!avs_waitrequest_o)
			avs_waitrequest_o <= 1'b1;
		else if (avs_read_i || avs_write_i)
			avs_waitrequest_o <= 1'b0;
	end

	// Read data captured while the answer is prepared
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
			avs_readdata_o <= 32'h0000_0000;
		else if (avs_read_i && avs_waitrequest_o)
			avs_readdata_o <= rd_val;
	end

	// Register read mux; unmapped words read as zero
	always_comb
	begin
		rd_val = 32'h0000_0000;
		case (avs_address_i)
			fdd_pkg::REG_CTRL: rd_val[3:0] = ctrl_r;
			fdd_pkg::REG_UV_THR: rd_val[15:0] = uv_thr_r;
			fdd_pkg::REG_OV_THR: rd_val[15:0] = ov_thr_r;
			fdd_pkg::REG_V_HYST: rd_val[15:0] = v_hyst_r;
			fdd_pkg::REG_T_THR: rd_val[15:0] = t_thr_r;
			fdd_pkg::REG_T_HYST: rd_val[15:0] = t_hyst_r;
			fdd_pkg::REG_DELAY: rd_val = {clr_dly_r, send_dly_r};
			fdd_pkg::REG_SA: rd_val[8:0] = {sa_en_r, sa_r};
			fdd_pkg::REG_STATUS: rd_val[12:0] = {outputs_disable_o, dtc_active_o, fault_w[3:0]};
			fdd_pkg::REG_REACT_ST: rd_val[29:0] = react_state_o;
			default:
			begin
				if (in_dtc)
					rd_val[8:0] = dtc_cfg_r[avs_address_i[4:2]];
				else if (in_occ)
					rd_val[7:0] = occ_r[avs_address_i[4:2]];
				else if (in_react)
					rd_val = react_cfg_r[avs_address_i[6:2]];
			end
		endcase
	end

	// Scalar settings written by software
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			ctrl_r <= fdd_pkg::CTRL_RST;
			uv_thr_r <= fdd_pkg::UV_THR_RST;
			ov_thr_r <= fdd_pkg::OV_THR_RST;
			v_hyst_r <= fdd_pkg::V_HYST_RST;
			t_thr_r <= fdd_pkg::T_THR_RST;
			t_hyst_r <= fdd_pkg::T_HYST_RST;
			send_dly_r <= fdd_pkg::DELAY_RST;
			clr_dly_r <= fdd_pkg::DELAY_RST;
			sa_r <= fdd_pkg::SA_RST;
			sa_en_r <= 1'b0;
		end
		else if (wr_en)
		begin
			case (avs_address_i)
				fdd_pkg::REG_CTRL: ctrl_r <= wdata[3:0];
				fdd_pkg::REG_UV_THR:
					if (volt_ok(wdata[15:0]))
						uv_thr_r <= wdata[15:0];
				fdd_pkg::REG_OV_THR:
					if (volt_ok(wdata[15:0]))
						ov_thr_r <= wdata[15:0];
				fdd_pkg::REG_V_HYST: v_hyst_r <= wdata[15:0];
				fdd_pkg::REG_T_THR: t_thr_r <= wdata[15:0];
				fdd_pkg::REG_T_HYST: t_hyst_r <= wdata[15:0];
				fdd_pkg::REG_DELAY:
				begin
					send_dly_r <= wdata[15:0];
					clr_dly_r <= wdata[31:16];
				end
				fdd_pkg::REG_SA:
				begin
					sa_en_r <= wdata[fdd_pkg::SA_EN_BIT];
					if (wdata[7:0] >= fdd_pkg::SA_MIN && wdata[7:0] <= fdd_pkg::SA_MAX)
						sa_r <= wdata[7:0];
				end
				default: ;
			endcase
		end
	end

	volt_range_a:
	assert property (@(posedge sys_clk_i) disable iff (reset_i)
		volt_ok(uv_thr_r) && volt_ok(ov_thr_r))
		else $error("voltage threshold outside supply range");

	// Millisecond tick for delays and expiry
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i || tick_cnt_r == fdd_pkg::TICK_W'(TICK_CYCLES - 1))
			tick_cnt_r <= '0;
		else
			tick_cnt_r <= tick_cnt_r + 1'b1;
	end

	always_ff @(posedge sys_clk_i)
	begin
		tick_r <= !reset_i && (tick_cnt_r == fdd_pkg::TICK_W'(TICK_CYCLES - 1));
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i || !ctrl_r[fdd_pkg::CTRL_PWR_EN])
			uv_r <= 1'b0;
		else if (supply_mv_i < uv_thr_r)
			uv_r <= 1'b1;
		else if ({1'b0, supply_mv_i} >= {1'b0, uv_thr_r} + {1'b0, v_hyst_r} &&
			(!dtc_cfg_r[fdd_pkg::DTC_UV][fdd_pkg::CFG_LATCH_BIT] || dm11_i))
			uv_r <= 1'b0;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i || !ctrl_r[fdd_pkg::CTRL_PWR_EN])
			ov_r <= 1'b0;
		else if (supply_mv_i > ov_thr_r)
			ov_r <= 1'b1;
		else if ({1'b0, supply_mv_i} + {1'b0, v_hyst_r} <= {1'b0, ov_thr_r} &&
			(!dtc_cfg_r[fdd_pkg::DTC_OV][fdd_pkg::CFG_LATCH_BIT] || dm11_i))
			ov_r <= 1'b0;
	end

	pwr_off_a:
	assert property (@(posedge sys_clk_i) disable iff (reset_i)
		!ctrl_r[fdd_pkg::CTRL_PWR_EN] |=> !uv_r && !ov_r)
		else $error("voltage error while detection disabled");

	uv_clear_a:
	assert property (@(posedge sys_clk_i) disable iff (reset_i)
		uv_r && ctrl_r[fdd_pkg::CTRL_PWR_EN] && !dtc_cfg_r[fdd_pkg::DTC_UV][fdd_pkg::CFG_LATCH_BIT]
		&& {1'b0, supply_mv_i} >= {1'b0, uv_thr_r} + {1'b0, v_hyst_r} |=> !uv_r)
		else $error("undervoltage not cleared at hysteresis point");

	ov_clear_a:
	assert property (@(posedge sys_clk_i) disable iff (reset_i)
		ov_r && ctrl_r[fdd_pkg::CTRL_PWR_EN] && !dtc_cfg_r[fdd_pkg::DTC_OV][fdd_pkg::CFG_LATCH_BIT]
		&& {1'b0, supply_mv_i} + {1'b0, v_hyst_r} <= {1'b0, ov_thr_r} |=> !ov_r)
		else $error("overvoltage not cleared at hysteresis point");

	uv_latch_a:
	assert property (@(posedge sys_clk_i) disable iff (reset_i)
		uv_r && ctrl_r[fdd_pkg::CTRL_PWR_EN] && !dm11_i
		&& dtc_cfg_r[fdd_pkg::DTC_UV][fdd_pkg::CFG_LATCH_BIT] |=> uv_r)
		else $error("latched undervoltage cleared without DM11");

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i || !ctrl_r[fdd_pkg::CTRL_TEMP_EN])
			ot_r <= 1'b0;
		else if (temperature_i >= t_thr_r)
			ot_r <= 1'b1;
		else if ({1'b0, temperature_i} + {1'b0, t_hyst_r} <= {1'b0, t_thr_r})
			ot_r <= 1'b0;
	end

	ot_set_a:
	assert property (@(posedge sys_clk_i) disable iff (reset_i)
		ctrl_r[fdd_pkg::CTRL_TEMP_EN] && temperature_i >= t_thr_r |=> ot_r)
		else $error("over-temperature not flagged");

	ot_clear_a:
	assert property (@(posedge sys_clk_i) disable iff (reset_i)
		{1'b0, temperature_i} + {1'b0, t_hyst_r} <= {1'b0, t_thr_r} && temperature_i < t_thr_r
		|=> !ot_r)
		else $error("over-temperature not cleared");

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
			can_r <= 1'b0;
		else if (can_rx_timeout_i)
			can_r <= 1'b1;
		else if (can_rx_msg_i)
			can_r <= 1'b0;
	end

	can_err_a:
	assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(can_rx_timeout_i |=> can_r) and (can_rx_msg_i && !can_rx_timeout_i |=> !can_r))
		else $error("CAN diagnostic error state wrong");

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
			outputs_disable_o <= 1'b0;
		else
			outputs_disable_o <= (ctrl_r[fdd_pkg::CTRL_PWR_DIS] && (uv_r || ov_r)) ||
				(ctrl_r[fdd_pkg::CTRL_OT_SD] && ot_r);
	end

	pwr_dis_a:
	assert property (@(posedge sys_clk_i) disable iff (reset_i)
		ctrl_r[fdd_pkg::CTRL_PWR_DIS] && (uv_r || ov_r) |=> outputs_disable_o)
		else $error("outputs not disabled on power fault");

	ot_sd_a:
	assert property (@(posedge sys_clk_i) disable iff (reset_i)
		ctrl_r[fdd_pkg::CTRL_OT_SD] && ot_r |=> outputs_disable_o)
		else $error("outputs not disabled on over-temperature");

	// Fault sources behind the four diagnostic trouble codes
	assign fault_w[fdd_pkg::N_DIAG-1:0] = {can_r, ot_r, ov_r, uv_r};

	// Per-input qualification against send and clear delays
	for (genvar k = 0; k < fdd_pkg::N_INP; k++)
	begin : g_inp
		assign fault_w[fdd_pkg::N_DIAG+k] = inp_q_r[k];

		always_ff @(posedge sys_clk_i)
		begin
			if (reset_i)
			begin
				inp_q_r[k] <= 1'b0;
				inp_cnt_r[k] <= 16'h0000;
			end
			else if (input_on_i[k] == inp_q_r[k])
				inp_cnt_r[k] <= 16'h0000;
			else if (inp_cnt_r[k] >= (inp_q_r[k] ? clr_dly_r : send_dly_r))
			begin
				inp_q_r[k] <= input_on_i[k];
				inp_cnt_r[k] <= 16'h0000;
			end
			else if (tick_r)
				inp_cnt_r[k] <= inp_cnt_r[k] + 16'h0001;
		end
	end

	// Trouble-code settings, activity and occurrence counts
	for (genvar k = 0; k < fdd_pkg::N_DTC; k++)
	begin : g_dtc
		assign dtc_active_o[k] = act_r[k];

		always_ff @(posedge sys_clk_i)
		begin
			if (reset_i)
				dtc_cfg_r[k] <= {1'b0, fdd_pkg::DTC_GEN_RST[k], fdd_pkg::LAMP_RST, fdd_pkg::FMI_RST};
			else if (wr_en && in_dtc && avs_address_i[4:2] == 3'(k))
			begin
				dtc_cfg_r[k][8:5] <= wdata[8:5];
				if (fmi_ok(wdata[4:0]))
					dtc_cfg_r[k][4:0] <= wdata[4:0];
			end
		end

		always_ff @(posedge sys_clk_i)
		begin
			if (reset_i || !dtc_cfg_r[k][fdd_pkg::CFG_GEN_BIT])
				act_r[k] <= 1'b0;
			else if (fault_w[k])
				act_r[k] <= 1'b1;
			else if (!dtc_cfg_r[k][fdd_pkg::CFG_LATCH_BIT] || dm11_i)
				act_r[k] <= 1'b0;
		end

		always_ff @(posedge sys_clk_i)
		begin
			if (reset_i)
				occ_r[k] <= 8'h00;
			else if (fault_w[k] && dtc_cfg_r[k][fdd_pkg::CFG_GEN_BIT] && !act_r[k])
				occ_r[k] <= dm3_i ? 8'h01 : occ_r[k] + {7'h00, occ_r[k] != 8'hff};
			else if (dm3_i)
				occ_r[k] <= 8'h00;
		end

		no_gen_a:
		assert property (@(posedge sys_clk_i) disable iff (reset_i)
			!dtc_cfg_r[k][fdd_pkg::CFG_GEN_BIT] |=> !act_r[k])
			else $error("trouble code active with generation off");

		latch_hold_a:
		assert property (@(posedge sys_clk_i) disable iff (reset_i)
			act_r[k] && dtc_cfg_r[k][fdd_pkg::CFG_GEN_BIT] && (fault_w[k] ||
			(dtc_cfg_r[k][fdd_pkg::CFG_LATCH_BIT] && !dm11_i)) |=> act_r[k])
			else $error("trouble code dropped too early");

		occ_keep_a:
		assert property (@(posedge sys_clk_i) disable iff (reset_i)
			act_r[k] && !dm3_i |=> occ_r[k] == $past(occ_r[k]))
			else $error("occurrence count changed while active");

		fmi_legal_a:
		assert property (@(posedge sys_clk_i) disable iff (reset_i)
			fmi_ok(dtc_cfg_r[k][4:0]))
			else $error("illegal failure mode code stored");
	end

	assign sa_ok = !sa_en_r || dm1_sa_i == sa_r;

	// Reaction table entries with expiry timers
	for (genvar k = 0; k < fdd_pkg::N_REACT; k++)
	begin : g_react
		assign react_state_o[k] = react_st_r[k];
		assign match_w[k] = dm1_valid_i && sa_ok && react_cfg_r[k][fdd_pkg::REACT_VALID_BIT] &&
			react_cfg_r[k][18:0] == dm1_spn_i &&
			react_cfg_r[k][fdd_pkg::REACT_FMI_LSB +: 5] == dm1_fmi_i;

		always_ff @(posedge sys_clk_i)
		begin
			if (reset_i)
				react_cfg_r[k] <= fdd_pkg::REACT_RST;
			else if (wr_en && in_react && avs_address_i[6:2] == 5'(k))
				react_cfg_r[k] <= wdata;
		end

		// set on match, expire after 3 s
		always_ff @(posedge sys_clk_i)
		begin
			if (reset_i)
			begin
				react_st_r[k] <= 1'b0;
				react_tmr_r[k] <= 12'h000;
			end
			else if (match_w[k])
			begin
				react_st_r[k] <= 1'b1;
				react_tmr_r[k] <= 12'h000;
			end
			else if (react_st_r[k] && react_tmr_r[k] >= fdd_pkg::REACT_TMR_MAX)
				react_st_r[k] <= 1'b0;
			else if (react_st_r[k] && tick_r)
				react_tmr_r[k] <= react_tmr_r[k] + 12'h001;
		end

		react_on_a:
		assert property (@(posedge sys_clk_i) disable iff (reset_i)
			match_w[k] |=> react_st_r[k] && react_tmr_r[k] == 12'h000)
			else $error("reaction state not set on match");

		react_off_a:
		assert property (@(posedge sys_clk_i) disable iff (reset_i)
			react_st_r[k] && react_tmr_r[k] >= fdd_pkg::REACT_TMR_MAX && !match_w[k]
			|=> !react_st_r[k])
			else $error("reaction state did not expire");
	end

endmodule

/* rtl/fdd_pkg.sv */
// Constants, types and register map of the diagnostics and trouble-code manager
package fdd_pkg;
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_W = 17;
	localparam int REACT_TIMEOUT_MS = 3000;
	localparam logic [11:0] REACT_TMR_MAX = 12'(REACT_TIMEOUT_MS);
	// Sizes and trouble-code indices
	localparam int N_DIAG = 4;
	localparam int N_INP = 4;
	localparam int N_DTC = 8;
	localparam int N_REACT = 30;
	localparam int DTC_UV = 0;
	localparam int DTC_OV = 1;
	localparam int DTC_OT = 2;
	localparam int DTC_CAN = 3;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_UV_THR = 8'h04;
	localparam logic [7:0] REG_OV_THR = 8'h08;
	localparam logic [7:0] REG_V_HYST = 8'h0c;
	localparam logic [7:0] REG_T_THR = 8'h10;
	localparam logic [7:0] REG_T_HYST = 8'h14;
	localparam logic [7:0] REG_DELAY = 8'h18;
	localparam logic [7:0] REG_SA = 8'h1c;
	localparam logic [7:0] REG_STATUS = 8'h20;
	localparam logic [7:0] REG_REACT_ST = 8'h24;
	localparam logic [7:0] REG_DTC_BASE = 8'h40;
	localparam logic [7:0] REG_OCC_BASE = 8'h60;
	localparam logic [7:0] REG_REACT_BASE = 8'h80;
	// Control bits and source-address enable bit
	localparam int CTRL_PWR_EN = 0;
	localparam int CTRL_TEMP_EN = 1;
	localparam int CTRL_PWR_DIS = 2;
	localparam int CTRL_OT_SD = 3;
	localparam int SA_EN_BIT = 8;
	// Trouble-code and reaction-table setting fields
	localparam int CFG_LAMP_LSB = 5;
	localparam int CFG_GEN_BIT = 7;
	localparam int CFG_LATCH_BIT = 8;
	localparam int REACT_FMI_LSB = 19;
	localparam int REACT_VALID_BIT = 31;
	// Limits
	localparam logic [15:0] VOLT_MIN_MV = 16'h2328;
	localparam logic [15:0] VOLT_MAX_MV = 16'h8ca0;
	localparam logic [4:0] FMI_LAST_RANGE = 5'h15;
	localparam logic [4:0] FMI_COND_EXISTS = 5'h1f;
	localparam logic [7:0] SA_MIN = 8'h01;
	localparam logic [7:0] SA_MAX = 8'hfd;
	// Values after reset
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [15:0] UV_THR_RST = 16'h2328;
	localparam logic [15:0] OV_THR_RST = 16'h8ca0;
	localparam logic [15:0] V_HYST_RST = 16'h01f4;
	localparam logic [15:0] T_THR_RST = 16'h007d;
	localparam logic [15:0] T_HYST_RST = 16'h0005;
	localparam logic [15:0] DELAY_RST = 16'h0000;
	localparam logic [7:0] SA_RST = 8'h01;
	localparam logic [7:0] DTC_GEN_RST = 8'h10;
	localparam logic [4:0] FMI_RST = 5'h1f;
	localparam logic [31:0] REACT_RST = 32'h0000_0000;
	typedef enum logic [1:0] {
		LAMP_PROTECT = 2'h0,
		LAMP_AMBER = 2'h1,
		LAMP_RED = 2'h2,
		LAMP_MALFUNCTION = 2'h3
	} fdd_lamp_e;
	localparam fdd_lamp_e LAMP_RST = LAMP_AMBER;
endpackage

/* bench/fdd_net_model.sv */
// Network partner model: DM1 entries, DM11, DM3 and CAN receive events
`timescale 1ns/1ps
module fdd_net_model (
	input wire logic clk_i,
	output logic dm1_valid_o,
	output logic [18:0] dm1_spn_o,
	output logic [4:0] dm1_fmi_o,
	output logic [7:0] dm1_sa_o,
	output logic dm11_o,
	output logic dm3_o,
	output logic rx_msg_o,
	output logic rx_timeout_o
);
	// Idle network, no events pending
	initial
	begin
		dm1_valid_o = 1'b0;
		dm1_spn_o = 19'h2aaaa;
		dm1_fmi_o = 5'h0a;
		dm1_sa_o = 8'h55;
		{dm11_o, dm3_o, rx_msg_o, rx_timeout_o} = 4'h0;
	end
	// One DM1 entry for one cycle; released fields then show the inverse
	// received entry
	task automatic send_dm1(input logic [18:0] spn, input logic [4:0] fmi,
		input logic [7:0] sa);
		@(posedge clk_i);
		dm1_valid_o <= 1'b1;
		dm1_spn_o <= spn;
		dm1_fmi_o <= fmi;
		dm1_sa_o <= sa;
		@(posedge clk_i);
		dm1_valid_o <= 1'b0;
		dm1_spn_o <= ~spn;
		dm1_fmi_o <= ~fmi;
		dm1_sa_o <= ~sa;
	endtask
	// One-cycle pulse on {dm11, dm3, rx message, rx timeout}
	// dm3 is the occurrence reset sent by network
	task automatic pulse(input logic [3:0] m);
		@(posedge clk_i);
		{dm11_o, dm3_o, rx_msg_o, rx_timeout_o} <= m;
		@(posedge clk_i);
		{dm11_o, dm3_o, rx_msg_o, rx_timeout_o} <= 4'h0;
	endtask
endmodule

/* bench/fdd_top_tb.sv */
// Self-checking testbench of the diagnostics and trouble-code manager
`timescale 1ns/1ps
module fdd_top_tb;
	localparam int TICK = 10;
	logic clk, rst, rd_r, wr_r, dv, d11, d3, cmsg, cto;
	logic [7:0] addr, sa, act;
	logic [31:0] wdat, rdat;
	logic wreq, odis;
	logic [15:0] sup, tmp;
	logic [3:0] inp;
	logic [3:0] be;
	logic [18:0] spn;
	logic [4:0] fmi;
	logic [29:0] rst_o;
	int mismatches, cmp_count;
	fdd_top #(.TICK_CYCLES(TICK)) u_fdd_top (.sys_clk_i(clk), .reset_i(rst),
		.avs_address_i(addr), .avs_read_i(rd_r), .avs_write_i(wr_r),
		.avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wreq), .supply_mv_i(sup), .temperature_i(tmp),
		.can_rx_timeout_i(cto), .can_rx_msg_i(cmsg), .input_on_i(inp),
		.dm11_i(d11), .dm3_i(d3), .dm1_valid_i(dv), .dm1_spn_i(spn),
		.dm1_fmi_i(fmi), .dm1_sa_i(sa), .dtc_active_o(act),
		.outputs_disable_o(odis), .react_state_o(rst_o));
	fdd_net_model u_net (.clk_i(clk), .dm1_valid_o(dv), .dm1_spn_o(spn),
		.dm1_fmi_o(fmi), .dm1_sa_o(sa), .dm11_o(d11), .dm3_o(d3),
		.rx_msg_o(cmsg), .rx_timeout_o(cto));
	// Clock generation
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Avalon access, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		addr <= a;
		wdat <= d;
		wr_r <= w;
		rd_r <= ~w;
		@(posedge clk);
		while (wreq !== 1'b0 && n < 100)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 100)
			chk(32'h0, 32'h1);
		q = rdat;
		wr_r <= 1'b0;
		rd_r <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	// Apply supply and temperature, then check {outputs_disable, flags}
	task automatic step(input logic [15:0] v, input logic [15:0] t, input logic [4:0] e);
		logic [31:0] q;
		@(posedge clk);
		sup <= v;
		tmp <= t;
		cyc(3);
		bus(1'b0, fdd_pkg::REG_STATUS, 32'h0, q);
		chk({27'h0, odis, q[3:0]}, {27'h0, e});
	endtask
	task automatic t_regs();
		rchk(fdd_pkg::REG_UV_THR, 32'h2328);
		wr(fdd_pkg::REG_UV_THR, 32'h1f40);
		rchk(fdd_pkg::REG_UV_THR, 32'h2328);
		wr(fdd_pkg::REG_OV_THR, 32'h8ca1);
		rchk(fdd_pkg::REG_OV_THR, 32'h8ca0);
		rchk(8'hfc, 32'h0);
		rchk(8'h50, 32'hbf);
		rchk(8'h44, 32'h3f);
		wr(8'h40, 32'h36);
		rchk(8'h40, 32'h3f);
		wr(8'h40, 32'h55);
		rchk(8'h40, 32'h55);
		wr(8'h40, 32'h3f);
		// Only the enabled byte lane of the delay word is written
		@(posedge clk);
		be <= 4'h2;
		wr(fdd_pkg::REG_DELAY, 32'h1234_5678);
		rchk(fdd_pkg::REG_DELAY, 32'h0000_5600);
		@(posedge clk);
		be <= 4'hf;
		$display("test regs done");
	endtask
	task automatic t_diag();
		wr(fdd_pkg::REG_CTRL, 32'h5);
		step(16'd8999, 16'd25, 5'h11);
		step(16'd9499, 16'd25, 5'h11);
		step(16'd9500, 16'd25, 5'h00);
		step(16'd36001, 16'd25, 5'h12);
		step(16'd35501, 16'd25, 5'h12);
		step(16'd35500, 16'd25, 5'h00);
		wr(8'h40, 32'h13f);
		step(16'd8000, 16'd25, 5'h11);
		step(16'd12000, 16'd25, 5'h11);
		u_net.pulse(4'h8);
		step(16'd12000, 16'd25, 5'h00);
		wr(8'h40, 32'h3f);
		wr(fdd_pkg::REG_CTRL, 32'h0);
		step(16'd8000, 16'd25, 5'h00);
		wr(fdd_pkg::REG_CTRL, 32'ha);
		step(16'd12000, 16'd124, 5'h00);
		step(16'd12000, 16'd125, 5'h14);
		step(16'd12000, 16'd121, 5'h14);
		step(16'd12000, 16'd120, 5'h00);
		$display("test diag done");
	endtask
	task automatic t_can();
		u_net.pulse(4'h1);
		cyc(3);
		rchk(fdd_pkg::REG_STATUS, 32'h8);
		u_net.pulse(4'h2);
		cyc(3);
		rchk(fdd_pkg::REG_STATUS, 32'h0);
		wr(8'h4c, 32'hbf);
		u_net.pulse(4'h1);
		cyc(3);
		chk(act, 8'h08);
		rchk(fdd_pkg::REG_STATUS, 32'h88);
		u_net.pulse(4'h2);
		cyc(3);
		chk(act, 8'h00);
		wr(8'h4c, 32'h1bf);
		u_net.pulse(4'h1);
		u_net.pulse(4'h2);
		cyc(3);
		chk(act, 8'h08);
		u_net.pulse(4'h1);
		u_net.pulse(4'h8);
		cyc(3);
		chk(act, 8'h08);
		u_net.pulse(4'h2);
		u_net.pulse(4'h8);
		cyc(3);
		chk(act, 8'h00);
		rchk(8'h6c, 32'h2);
		u_net.pulse(4'h4);
		cyc(3);
		rchk(8'h6c, 32'h0);
		$display("test can done");
	endtask
	task automatic t_inp();
		wr(fdd_pkg::REG_DELAY, 32'h0002_0003);
		@(posedge clk);
		inp <= 4'h1;
		cyc(15);
		inp <= 4'h0;
		cyc(40);
		chk(act, 8'h00);
		inp <= 4'h1;
		cyc(15);
		chk(act, 8'h00);
		cyc(45);
		chk(act, 8'h10);
		rchk(8'h70, 32'h1);
		@(posedge clk);
		inp <= 4'h0;
		cyc(5);
		chk(act, 8'h10);
		cyc(40);
		chk(act, 8'h00);
		$display("test inputs done");
	endtask
	task automatic t_react();
		wr(8'h80, 32'h8000_0000 | (32'h5 << 19) | 32'h1234);
		wr(fdd_pkg::REG_SA, 32'h105);
		wr(fdd_pkg::REG_SA, 32'h1fe);
		rchk(fdd_pkg::REG_SA, 32'h1fe & 32'h100 | 32'h5);
		u_net.send_dm1(19'h1234, 5'h5, 8'h6);
		cyc(3);
		chk({2'h0, rst_o}, 32'h0);
		u_net.send_dm1(19'h1234, 5'h4, 8'h5);
		cyc(3);
		chk({2'h0, rst_o}, 32'h0);
		u_net.send_dm1(19'h1234, 5'h5, 8'h5);
		cyc(3);
		chk({2'h0, rst_o}, 32'h1);
		rchk(fdd_pkg::REG_REACT_ST, 32'h1);
		cyc(3000 * TICK - 100);
		chk({2'h0, rst_o}, 32'h1);
		cyc(200);
		chk({2'h0, rst_o}, 32'h0);
		$display("test react done");
	endtask
	// Verdict and end of run
	task automatic end_sim();
		$display("mismatches %0d comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Watchdog sized well above the expected run
	initial
	begin
		#(60000 * 10);
		mismatches++;
		end_sim();
	end
	// Main sequence
	initial
	begin
		mismatches = 0;
		cmp_count = 0;
		rst = 1'b1;
		{rd_r, wr_r} = 2'h0;
		addr = 8'h0;
		wdat = 32'h0;
		sup = 16'd12000;
		tmp = 16'd25;
		inp = 4'h0;
		be = 4'hf;
		cyc(3);
		rst <= 1'b0;
		chk({odis, act}, 9'h0);
		t_regs();
		t_diag();
		t_can();
		t_inp();
		t_react();
		end_sim();
	end
endmodule
